// *** rtl/asp_map.svh ***
// register offsets, field positions, reset values and counts of the port
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
`define ASP_ADDR_STATUS 6'h00
`define ASP_ADDR_IFMODE 6'h02
`define ASP_ADDR_DATA 6'h04
`define ASP_CMD_RD_BIT 6
`define ASP_IFM_CONT_BIT 7
`define ASP_IFM_STAT_BIT 6
`define ASP_IFM_CHK_LSB 2
`define ASP_IFMODE_RST 16'h0000
`define ASP_DATA_RST 24'h000000
`define ASP_STS_RDY_BIT 7
`define ASP_STS_CRC_BIT 6
`define ASP_CHK_OFF 2'h0
`define ASP_CHK_XOR 2'h1
`define ASP_CRC_POLY 8'h07
`define ASP_CONT_CMD 8'h44
`define ASP_RESET_LAST 7'h3f
`define ASP_LEN_BYTE 6'h08
`define ASP_LEN_HALF 6'h10
`define ASP_LEN_WORD 6'h18
`define ASP_LEN_STAT 6'h20
`define ASP_UPD_LEAD 2'h2
`endif

// *** rtl/asp_pkg.sv ***
// types shared by the serial port, the host model and the testbench
package asp_pkg;
   typedef enum logic [1:0] {st_cmd, st_wr, st_rd, st_cont} asp_state_t;
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic din;
   } asp_pins_t;
   typedef struct packed {
      logic [3:0] chan;
      logic [23:0] data;
   } asp_conv_t;
endpackage : asp_pkg

// *** rtl/asp_fifo.sv ***
// conversion word buffer with registered read data
`timescale 1ns/1ps
module asp_fifo #(
   parameter int WIDTH = 28,
   parameter int DEPTH = 32
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_valid,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_ready,
   output logic o_valid,
   output logic [WIDTH-1:0] o_data,
   input wire logic i_ready
);
   // depth must be a power of two: the pointers wrap on their own
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic [AW:0] cnt_d;
   logic rdy_q;
   logic ov_q;
   logic [WIDTH-1:0] od_q;
   logic wr;
   logic ld;

   assign wr = i_valid & rdy_q;
   assign ld = (~ov_q | i_ready) & (cnt_q != '0);
   assign cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(ld);

   always_ff @(posedge i_clk) begin
      if (wr) begin
         mem[wp_q] <= i_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         rdy_q <= 1'b1;
      end else begin
         wp_q <= wp_q + AW'(wr);
         rp_q <= rp_q + AW'(ld);
         cnt_q <= cnt_d;
         // ready held in a register so the port output leaves a flip-flop
         rdy_q <= (cnt_d != (AW+1)'(DEPTH));
      end
   end

   // output stage keeps read data in a register
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ov_q <= 1'b0;
         od_q <= '0;
      end else if (ld) begin
         ov_q <= 1'b1;
         od_q <= mem[rp_q];
      end else if (i_ready) begin
         ov_q <= 1'b0;
      end
   end

   assign o_ready = rdy_q;
   assign o_valid = ov_q;
   assign o_data = od_q;
endmodule : asp_fifo

// *** rtl/asp_serial_port.sv ***
// converter-side serial port with ready signalling and checksums
//
// Overview of operation
// - four lines: select, data in, host clock, shared data-out/ready
// - new word present and select low: output line driven low
// - completed data register read returns the ready line high
// - ready goes high before the data register is updated
// - repeated reads allowed; continuous mode reads each result once
// - select tied low gives 3-wire use; status bit shows ready
// - 64 clocks with data in high reset port and all registers
// - bad write checksum sets fault flag; host verifies by readback
// - write checksums always use polynomial x^8 + x^2 + x + 1
// - checksum select field: off, polynomial, or xor for reads
// - 8-bit checksum appended; writes cover command then data
// - read checksum covers command, data and appended status byte
// - continuous read checksum includes implied command 0x44
// - polynomial remainder of data with eight zeros, no seed
// - xor option folds all covered bytes together
// - continuous read left by command 0x44 or interface reset
// - append-status sends status byte after the conversion word
// - fault flag stays set until status register is read or interface reset
`timescale 1ns/1ps
`include "asp_map.svh"
module asp_serial_port import asp_pkg::*; #(
   parameter int FIFO_DEPTH = 32
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire asp_pins_t i_pins,
   input wire logic i_conv_valid,
   input wire asp_conv_t i_conv,
   output logic o_conv_ready,
   output logic o_dout_rdy,
   output logic o_dout_oe_n,
   output logic [15:0] o_ifmode,
   output logic o_crc_fault,
   output logic o_sw_reset
);
   // ************************************************************
   // checksum and length helpers
   // ************************************************************
   function automatic logic [7:0] crc_step(input logic [7:0] c,
                                           input logic b);
      logic fb;
      fb = c[7] ^ b;
      return {c[6:0], 1'b0} ^ (fb ? `ASP_CRC_POLY : 8'h00);
   endfunction : crc_step

   function automatic logic [7:0] crc_byte(input logic [7:0] v);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         c = crc_step(c, v[i]);
      end
      return c;
   endfunction : crc_byte

   function automatic logic [7:0] xor_step(input logic [7:0] x,
                                           input logic [2:0] idx,
                                           input logic b);
      return x ^ ({7'h00, b} << (3'h7 - idx));
   endfunction : xor_step

   function automatic logic [5:0] len_of(input logic [5:0] a,
                                         input logic stat);
      case (a)
         `ASP_ADDR_DATA: len_of = stat ? `ASP_LEN_STAT : `ASP_LEN_WORD;
         `ASP_ADDR_IFMODE: len_of = `ASP_LEN_HALF;
         default: len_of = `ASP_LEN_BYTE;
      endcase
   endfunction : len_of

   localparam logic [7:0] CONT_CRC = crc_byte(`ASP_CONT_CMD);

   // ************************************************************
   // pin synchronisers and clock edges
   // ************************************************************
   asp_pins_t pins_m_q;
   asp_pins_t pins_s_q;
   logic sclk_p_q;
   logic rise;
   logic fall;
   logic cs_low;
   logic din;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pins_m_q <= '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};
         pins_s_q <= '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};
         sclk_p_q <= 1'b1;
      end else begin
         pins_m_q <= i_pins;
         pins_s_q <= pins_m_q;
         sclk_p_q <= pins_s_q.sclk;
      end
   end

   // every transfer is timed by host clock edges found here
   assign rise = pins_s_q.sclk & ~sclk_p_q;
   assign fall = ~pins_s_q.sclk & sclk_p_q;
   assign cs_low = ~pins_s_q.cs_n;
   assign din = pins_s_q.din;

   // ************************************************************
   // shared state and decode
   // ************************************************************
   asp_state_t st_q;
   logic [5:0] cnt_q;
   logic [5:0] len_q;
   logic [5:0] tot_q;
   logic [5:0] addr_q;
   logic is_data_q;
   logic is_cont_q;
   logic [31:0] tx_q;
   logic [31:0] rx_q;
   logic [7:0] crc_q;
   logic [7:0] xor_q;
   logic [15:0] ifmode_q;
   logic fault_q;
   asp_conv_t data_q;
   logic new_q;
   logic [1:0] upd_q;
   logic [6:0] rst_cnt_q;
   logic dout_q;
   logic oe_n_q;
   logic swrst_q;
   logic f_v;
   logic f_rdy;
   logic [$bits(asp_conv_t)-1:0] f_data;
   logic chk_on;
   logic [7:0] chk;
   logic [7:0] sts;
   logic [7:0] cmd_byte;
   logic [5:0] l_new;
   logic [5:0] l_cont;
   logic [31:0] wr_full;
   logic [15:0] wr_val;
   logic wr_ok;
   logic last;
   logic done_rd;
   logic done_wr;
   logic rst_hit;
   logic rd_blk;
   logic data_load;
   logic tx_bit;
   logic stat_on;
   asp_state_t nxt_idle;

   assign chk_on = ifmode_q[`ASP_IFM_CHK_LSB +: 2] != `ASP_CHK_OFF;
   assign stat_on = ifmode_q[`ASP_IFM_STAT_BIT];
   // polynomial unless xor is chosen; xor applies to reads only
   assign chk = (ifmode_q[`ASP_IFM_CHK_LSB +: 2] == `ASP_CHK_XOR) ?
                xor_q : crc_q;
   always_comb begin
      sts = 8'h00;
      sts[`ASP_STS_RDY_BIT] = ~new_q;
      sts[`ASP_STS_CRC_BIT] = fault_q;
      sts[3:0] = data_q.chan;
   end
   assign cmd_byte = {rx_q[6:0], din};
   assign l_new = len_of(cmd_byte[5:0], stat_on);
   assign l_cont = len_of(`ASP_ADDR_DATA, stat_on);
   assign wr_full = {rx_q[30:0], din};
   assign wr_val = chk_on ? wr_full[23:8] : wr_full[15:0];
   assign wr_ok = !chk_on || (wr_full[7:0] == crc_q);
   assign last = rise && (cnt_q == tot_q - 6'h01);
   assign done_rd = last && (st_q == st_rd);
   assign done_wr = last && (st_q == st_wr);
   assign rst_hit = rise && cs_low && din &&
                    (rst_cnt_q == `ASP_RESET_LAST);
   assign rd_blk = (st_q == st_rd) && is_data_q;
   assign data_load = (upd_q == `ASP_UPD_LEAD) && !rd_blk;
   assign f_rdy = data_load && !rst_hit;
   assign tx_bit = (cnt_q == len_q) ? chk[7] : tx_q[31];
   assign nxt_idle = (ifmode_q[`ASP_IFM_CONT_BIT] && !rst_hit) ?
                     st_cont : st_cmd;

   // left-justified read image: word then optional status byte
   function automatic logic [31:0] load_of(input logic [5:0] a,
                                           input asp_conv_t d,
                                           input logic [7:0] s,
                                           input logic [15:0] m);
      case (a)
         `ASP_ADDR_DATA: load_of = {d.data, s};
         `ASP_ADDR_STATUS: load_of = {s, 24'h000000};
         `ASP_ADDR_IFMODE: load_of = {m, 16'h0000};
         default: load_of = 32'h00000000;
      endcase
   endfunction : load_of

   // ************************************************************
   // transaction sequencer
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_q <= st_cmd;
         cnt_q <= 6'h00;
         len_q <= 6'h00;
         tot_q <= 6'h00;
         addr_q <= 6'h00;
         is_data_q <= 1'b0;
         is_cont_q <= 1'b0;
         tx_q <= 32'h00000000;
         rx_q <= 32'h00000000;
         crc_q <= 8'h00;
         xor_q <= 8'h00;
      end else if (rst_hit || !cs_low) begin
         st_q <= rst_hit ? st_cmd : nxt_idle;
         cnt_q <= 6'h00;
         rx_q <= 32'h00000000;
         crc_q <= 8'h00;
         xor_q <= 8'h00;
         is_data_q <= 1'b0;
      end else begin
         case (st_q)
            st_cmd: begin
               if (rise) begin
                  rx_q <= wr_full;
                  crc_q <= crc_step(crc_q, din);
                  xor_q <= xor_step(xor_q, cnt_q[2:0], din);
                  cnt_q <= cnt_q + 6'h01;
                  if (cnt_q == 6'h07) begin
                     cnt_q <= 6'h00;
                     addr_q <= cmd_byte[5:0];
                     len_q <= l_new;
                     tot_q <= l_new + (chk_on ? 6'h08 : 6'h00);
                     is_cont_q <= 1'b0;
                     if (cmd_byte[`ASP_CMD_RD_BIT]) begin
                        st_q <= st_rd;
                        // repeated reads of the same word are allowed
                        is_data_q <= cmd_byte[5:0] == `ASP_ADDR_DATA;
                        tx_q <= load_of(cmd_byte[5:0], data_q, sts,
                                        ifmode_q);
                     end else begin
                        st_q <= st_wr;
                     end
                  end
               end
            end
            st_wr: begin
               if (rise) begin
                  rx_q <= wr_full;
                  if (cnt_q < len_q) begin
                     crc_q <= crc_step(crc_q, din);
                     xor_q <= xor_step(xor_q, cnt_q[2:0], din);
                  end
                  cnt_q <= cnt_q + 6'h01;
                  if (last) begin
                     st_q <= nxt_idle;
                     cnt_q <= 6'h00;
                     crc_q <= 8'h00;
                     xor_q <= 8'h00;
                  end
               end
            end
            st_rd: begin
               if (fall && (cnt_q < tot_q)) begin
                  if (cnt_q == len_q) begin
                     tx_q <= {chk[6:0], 25'h0000000};
                  end else begin
                     tx_q <= {tx_q[30:0], 1'b0};
                     crc_q <= crc_step(crc_q, tx_q[31]);
                     xor_q <= xor_step(xor_q, cnt_q[2:0], tx_q[31]);
                  end
               end
               if (rise) begin
                  rx_q <= wr_full;
                  cnt_q <= cnt_q + 6'h01;
                  if (last) begin
                     st_q <= nxt_idle;
                     cnt_q <= 6'h00;
                     crc_q <= 8'h00;
                     xor_q <= 8'h00;
                     is_data_q <= 1'b0;
                  end
               end
            end
            st_cont: begin
               // one preloaded read per fresh result
               if (new_q) begin
                  st_q <= st_rd;
                  addr_q <= `ASP_ADDR_DATA;
                  is_data_q <= 1'b1;
                  is_cont_q <= 1'b1;
                  len_q <= l_cont;
                  tot_q <= l_cont + (chk_on ? 6'h08 : 6'h00);
                  tx_q <= load_of(`ASP_ADDR_DATA, data_q, sts, ifmode_q);
                  crc_q <= CONT_CRC;
                  xor_q <= `ASP_CONT_CMD;
                  cnt_q <= 6'h00;
               end
            end
            default: begin
               st_q <= st_cmd;
            end
         endcase
      end
   end

   // ************************************************************
   // mode register
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ifmode_q <= `ASP_IFMODE_RST;
      end else if (rst_hit) begin
         ifmode_q <= `ASP_IFMODE_RST;
      end else if (done_wr && wr_ok &&
                   (addr_q == `ASP_ADDR_IFMODE)) begin
         ifmode_q <= wr_val;
      end else if ((st_q == st_rd) && is_cont_q && rise &&
                   (cnt_q == 6'h07) && (cmd_byte == `ASP_CONT_CMD)) begin
         ifmode_q[`ASP_IFM_CONT_BIT] <= 1'b0;
      end
   end

   // ************************************************************
   // checksum fault flag
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         fault_q <= 1'b0;
      end else if (done_wr && !wr_ok) begin
         fault_q <= 1'b1;
      end else if (rst_hit) begin
         fault_q <= 1'b0;
      end else if (done_rd && (addr_q == `ASP_ADDR_STATUS)) begin
         fault_q <= 1'b0;
      end
   end

   // ************************************************************
   // data register update
   // ************************************************************
   // a word waits in the buffer while a data read is under way
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         data_q <= '{chan: 4'h0, data: `ASP_DATA_RST};
         new_q <= 1'b0;
         upd_q <= 2'h0;
      end else if (rst_hit) begin
         data_q <= '{chan: 4'h0, data: `ASP_DATA_RST};
         new_q <= 1'b0;
         upd_q <= 2'h0;
      end else begin
         if (done_rd && is_data_q) begin
            new_q <= 1'b0;
         end
         if (data_load) begin
            data_q <= asp_conv_t'(f_data);
            new_q <= 1'b1;
            upd_q <= 2'h0;
         end else if (upd_q != 2'h0) begin
            upd_q <= upd_q + 2'h1;
         end else if (f_v && !rd_blk) begin
            upd_q <= 2'h1;
            new_q <= 1'b0;
         end
      end
   end

   // ************************************************************
   // shared output line and interface reset counter
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         dout_q <= 1'b1;
         oe_n_q <= 1'b1;
      end else begin
         oe_n_q <= ~cs_low;
         if ((st_q == st_rd) && fall && (cnt_q < tot_q)) begin
            dout_q <= tx_bit;
         end else if (st_q != st_rd) begin
            dout_q <= ~(new_q & cs_low);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_cnt_q <= 7'h00;
         swrst_q <= 1'b0;
      end else begin
         swrst_q <= rst_hit;
         if (!cs_low || rst_hit) begin
            rst_cnt_q <= 7'h00;
         end else if (rise) begin
            rst_cnt_q <= din ? rst_cnt_q + 7'h01 : 7'h00;
         end
      end
   end

   asp_fifo #(
      .WIDTH($bits(asp_conv_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_valid(i_conv_valid),
      .i_data(i_conv),
      .o_ready(o_conv_ready),
      .o_valid(f_v),
      .o_data(f_data),
      .i_ready(f_rdy)
   );

   assign o_dout_rdy = dout_q;
   assign o_dout_oe_n = oe_n_q;
   assign o_ifmode = ifmode_q;
   assign o_crc_fault = fault_q;
   assign o_sw_reset = swrst_q;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   sequence s_rdy_back;
      !new_q ##1 o_dout_rdy;
   endsequence

   property p_rdy_low;
      (st_q != st_rd && cs_low && new_q) |=> !o_dout_rdy;
   endproperty
   a_rdy_low: assert property (p_rdy_low)
      else $error("ready not low with new word");

   property p_rdy_back;
      (done_rd && is_data_q) |=> s_rdy_back;
   endproperty
   a_rdy_back: assert property (p_rdy_back)
      else $error("ready not high after data read");

   property p_upd_lead;
      data_load |-> !new_q && $past(!new_q) &&
                   (o_dout_rdy || st_q == st_rd);
   endproperty
   a_upd_lead: assert property (p_upd_lead)
      else $error("data updated without ready high");

   property p_cont_once;
      ($past(st_q) == st_cont && st_q == st_rd) |-> $past(new_q);
   endproperty
   a_cont_once: assert property (p_cont_once)
      else $error("continuous read without fresh word");

   property p_swreset;
      rst_hit |=> st_q == st_cmd && o_ifmode == `ASP_IFMODE_RST &&
                 !new_q && o_sw_reset;
   endproperty
   a_swreset: assert property (p_swreset)
      else $error("interface reset incomplete");

   property p_bad_wr;
      (done_wr && !wr_ok) |=> o_crc_fault && $stable(ifmode_q);
   endproperty
   a_bad_wr: assert property (p_bad_wr)
      else $error("bad checksum write not handled");

   property p_flt_clr;
      (done_rd && addr_q == `ASP_ADDR_STATUS) |=> !o_crc_fault;
   endproperty
   a_flt_clr: assert property (p_flt_clr)
      else $error("fault flag not cleared by status read");

   property p_cont_seed;
      ($past(st_q) == st_cont && st_q == st_rd) |->
         crc_q == CONT_CRC && xor_q == `ASP_CONT_CMD;
   endproperty
   a_cont_seed: assert property (p_cont_seed)
      else $error("continuous checksum not seeded with command");

   property p_stat_len;
      (st_q == st_rd && is_data_q) |->
         len_q == (stat_on ? `ASP_LEN_STAT : `ASP_LEN_WORD);
   endproperty
   a_stat_len: assert property (p_stat_len)
      else $error("data read length wrong");

   property p_chk_len;
      (st_q == st_rd || st_q == st_wr) |->
         tot_q == len_q + (chk_on ? 6'h08 : 6'h00);
   endproperty
   a_chk_len: assert property (p_chk_len)
      else $error("checksum byte not appended");
endmodule : asp_serial_port

// *** tb/asp_host_model.sv ***
// host side model that drives the serial pins of the port
`timescale 1ns/1ps
module asp_host_model import asp_pkg::*; (
   input wire logic i_clk,
   input wire logic i_dout,
   output asp_pins_t o_pins,
   output logic [63:0] o_rx,
   output logic o_done
);
   // ****************************************
   // mode 3 frame, sclk idles high
   // ****************************************
   initial begin
      o_pins = 3'b110;
      o_rx = 64'h0;
      o_done = 1'b0;
   end
   // dout is taken late in the high phase, the device answers 3 cycles
   // after each fall, so the bit has long settled
   task automatic xfer(input int n, input logic [63:0] tx, input logic w,
      input logic d);
      o_pins.cs_n <= 1'b0;
      o_rx <= 64'h0;
      repeat (8) @(posedge i_clk);
      for (int k = 0; k < 3000 && w && i_dout !== 1'b0; k++) begin
         @(posedge i_clk);
      end
      for (int i = n - 1; i >= 0; i--) begin
         o_pins.sclk <= 1'b0;
         o_pins.din <= tx[i];
         repeat (4) @(posedge i_clk);
         o_pins.sclk <= 1'b1;
         repeat (4) @(posedge i_clk);
         o_rx <= {o_rx[62:0], i_dout};
      end
      o_pins.cs_n <= 1'b1;
      o_pins.din <= ~tx[0];
      o_done <= d;
      @(posedge i_clk);
      o_done <= 1'b0;
      repeat (8) @(posedge i_clk);
   endtask : xfer
endmodule : asp_host_model

// *** tb/testbench.sv ***
// self-checking bench for the converter serial port
`timescale 1ns/1ps
module testbench import asp_pkg::*;;
   logic clk, resetn, conv_valid, conv_ready, dout_rdy, dout_oe_n;
   logic crc_fault, sw_reset, done, saw_rst;
   logic [15:0] ifmode;
   logic [63:0] rx;
   logic [127:0] e;
   logic [127:0] expq[$];
   logic [7:0] st;
   logic [39:0] v;
   asp_pins_t pins;
   asp_conv_t conv, c;
   int failures, samples_checked;
   integer seed;
   asp_serial_port #(.FIFO_DEPTH(32)) uut (.i_clk(clk), .i_resetn(resetn),
      .i_pins(pins), .i_conv_valid(conv_valid), .i_conv(conv),
      .o_conv_ready(conv_ready), .o_dout_rdy(dout_rdy),
      .o_dout_oe_n(dout_oe_n), .o_ifmode(ifmode), .o_crc_fault(crc_fault),
      .o_sw_reset(sw_reset));
   asp_host_model host (.i_clk(clk), .i_dout(dout_rdy), .o_pins(pins),
      .o_rx(rx), .o_done(done));
   // ****************************************
   // helpers
   // ****************************************
   always #10 clk = ~clk;
   function automatic logic [7:0] crc8(input logic [63:0] x, input int n);
      logic [7:0] r;
      r = 8'h00;
      for (int i = n - 1; i >= 0; i--) begin
         r = {r[6:0], 1'b0} ^ ((r[7] ^ x[i]) ? 8'h07 : 8'h00);
      end
      return r;
   endfunction : crc8
   function automatic logic [7:0] xor8(input logic [63:0] x, input int n);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < n; i += 8) begin
         r ^= x[i+:8];
      end
      return r;
   endfunction : xor8
   // continuous read image: data and checksum behind an implied command
   function automatic logic [127:0] cexp(input logic [23:0] d);
      return {64'hffff_ffff, 32'h0, d, crc8({8'h44, d}, 32)};
   endfunction : cexp
   task automatic cmp(input logic [63:0] g, input logic [63:0] x);
      samples_checked++;
      if (g !== x) begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : cmp
   task automatic wr(input logic [15:0] d, input logic ck, input logic [7:0] b);
      logic [23:0] w;
      w = {8'h02, d};
      @(posedge clk);
      if (ck) host.xfer(32, {w, crc8(w, 24) ^ b}, 1'b0, 1'b0);
      else host.xfer(24, w, 1'b0, 1'b0);
   endtask : wr
   task automatic push(input asp_conv_t x);
      @(posedge clk);
      conv_valid <= 1'b1;
      conv <= x;
      do @(negedge clk); while (conv_ready !== 1'b1);
      @(posedge clk);
      conv_valid <= 1'b0;
   endtask : push
   task automatic rd(input int n, input logic [63:0] tx, input logic [63:0] m,
      input logic [63:0] x, input logic w);
      expq.push_back({m, x});
      @(posedge clk);
      host.xfer(n, tx, w, 1'b1);
   endtask : rd
   task automatic end_sim;
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   always @(posedge clk) begin
      if (sw_reset === 1'b1) saw_rst <= 1'b1;
      if (done === 1'b1) begin
         e = expq.pop_front();
         cmp(rx & e[127:64], e[63:0]);
      end
   end
   initial begin
      repeat (90000) @(posedge clk);
      failures++;
      end_sim;
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      clk = 0; resetn = 0; conv_valid = 0; conv = '0; saw_rst = 0;
      failures = 0; samples_checked = 0; seed = 32'h71dd1a70;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      cmp({dout_rdy, dout_oe_n, crc_fault, ifmode}, 19'h60000);
      wr(16'h0048, 1'b0, 8'h00);
      cmp(ifmode, 16'h0048);
      wr(16'h0044, 1'b1, 8'h01);
      cmp({crc_fault, ifmode}, {1'b1, 16'h0048});
      wr(16'h0044, 1'b1, 8'h00);
      cmp({crc_fault, ifmode}, {1'b1, 16'h0044});
      $display("test checksum writes done");
      c = 28'($random(seed));
      push(c);
      v = {8'h44, c.data, 4'h4, c.chan};
      rd(48, {8'h44, 40'h0}, 64'hff_ffff_ffff, {v[31:0], xor8(v, 40)}, 1);
      st = {4'hc, c.chan};
      rd(24, {8'h40, 16'h0}, 64'hff_ffff, {8'hff, st, xor8({8'h40, st}, 16)}, 0);
      cmp(crc_fault, 1'b0);
      v = {8'h44, c.data, 4'h8, c.chan};
      rd(48, {8'h44, 40'h0}, 64'hffff_ffff_ffff, {8'hff, v[31:0], xor8(v, 40)}, 0);
      $display("test data reads done");
      wr(16'h0088, 1'b1, 8'h00);
      // a word is replaced by the next one unless a data read holds it
      for (int k = 0; k < 4; k++) begin
         c = 28'($random(seed));
         push(c);
         expq.push_back(cexp(c.data));
         if (k < 3) begin
            @(posedge clk);
            host.xfer(32, 64'h0, 1'b1, 1'b1);
         end
      end
      fork
         host.xfer(32, 64'h0, 1'b1, 1'b1);
         begin
            repeat (24) @(posedge clk);
            for (int k = 0; k < 33; k++) begin
               c = 28'($random(seed));
               push(c);
            end
            repeat (2) @(posedge clk);
            cmp(conv_ready, 1'b0);
         end
      join
      // backlog drains after the read, the last word stays for the host
      repeat (150) @(posedge clk);
      expq.push_back(cexp(c.data));
      host.xfer(32, 64'h4400_0000, 1'b1, 1'b1);
      cmp({conv_ready, expq.size() == 0}, 2'b11);
      cmp(ifmode, 16'h0008);
      $display("test continuous reads done");
      @(posedge clk);
      host.xfer(64, '1, 1'b0, 1'b0);
      cmp({saw_rst, ifmode}, {1'b1, 16'h0000});
      repeat (25000) @(posedge clk);
      rd(16, {8'h40, 8'h0}, 64'hff, 64'h80, 1'b0);
      repeat (20) @(posedge clk);
      $display("test interface reset done");
      end_sim;
   end
endmodule : testbench
